// >>> flash_cache_sram_ports.sv
/*
 * Flash cache SRAM side: power handshake, data and tag SRAM ports for
 * way 0 and optional way 1, lookup and fill sequencing, hit/miss pulses.
 * Assumes the cache controller offers lookups and fills on a plain
 * valid/ready port, and that SRAM read data returns one cycle after the
 * address cycle. The power acknowledge may arrive from any domain.
 */
// Functional notes
// - Bus clock drives all always-on logic
// - Active-low reset acts asynchronously
// - Parameter chooses full or partial reset
// - Power request driven straight from flop
// - Power acknowledge synchronised before use
// - Request power; acknowledge only when usable
// - Way 0 always; way 1 optional
// - Data address width is cache width minus four
// - One line write control per way
// - Four word read and select controls
// - Write data with address, write control
// - Read data sampled one cycle later
// - Tag ports: index, controls, tag data
// - One-cycle pulse per lookup miss
// - One-cycle pulse per lookup hit
`timescale 1ns/1ps
module flash_cache_sram_ports #(
    parameter int cache_width_param   = flash_cache_sram_pkg::DEF_CW,
    parameter int address_width_param = flash_cache_sram_pkg::DEF_AW,
    parameter bit WAY1_PRESENT        = 1'b1,
    parameter bit RESET_ALL_REGS      = 1'b1
) (
    // Clock and reset
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    // Power control
    input  wire logic                         power_request_bit,
    output logic                              power_state_field,
    output logic                              sram_power_up_request,
    input  wire logic                         sram_power_up_ack,
    // Lookup request and answer
    input  wire logic                         lookup_valid,
    output logic                              lookup_ready,
    input  wire logic [address_width_param-1:0] lookup_addr,
    output logic                              resp_valid,
    output logic                              resp_hit,
    output logic                              resp_way,
    output logic [flash_cache_sram_pkg::LINE_BITS-1:0] resp_data,
    // Line fill
    input  wire logic                         fill_valid,
    output logic                              fill_ready,
    input  wire logic                         fill_way,
    input  wire logic [address_width_param-1:0] fill_addr,
    input  wire logic [flash_cache_sram_pkg::LINE_BITS-1:0] fill_data,
    // Way 0 data SRAM
    output logic [cache_width_param-5:0]      way0_line_addr,
    output logic                              way0_line_write,
    output logic [3:0]                        way0_line_word_read,
    output logic [3:0]                        way0_line_word_select,
    output logic [127:0]                      way0_line_wdata,
    input  wire logic [127:0]                 way0_line_rdata,
    // Way 1 data SRAM
    output logic [cache_width_param-5:0]      way1_line_addr,
    output logic                              way1_line_write,
    output logic [3:0]                        way1_line_word_read,
    output logic [3:0]                        way1_line_word_select,
    output logic [127:0]                      way1_line_wdata,
    input  wire logic [127:0]                 way1_line_rdata,
    // Way 0 tag SRAM
    output logic [cache_width_param-5:0]      way0_tag_addr,
    output logic                              way0_tag_write,
    output logic                              way0_tag_read,
    output logic                              way0_tag_select,
    output logic [address_width_param-cache_width_param:0] way0_tag_wdata,
    input  wire logic [address_width_param-cache_width_param:0] way0_tag_rdata,
    // Way 1 tag SRAM
    output logic [cache_width_param-5:0]      way1_tag_addr,
    output logic                              way1_tag_write,
    output logic                              way1_tag_read,
    output logic                              way1_tag_select,
    output logic [address_width_param-cache_width_param:0] way1_tag_wdata,
    input  wire logic [address_width_param-cache_width_param:0] way1_tag_rdata,
    // Statistics
    output logic                              lookup_miss_pulse,
    output logic                              lookup_hit_pulse
);
    import flash_cache_sram_pkg::*;

    localparam int IW = cache_width_param - LINE_OFFSET;
    localparam int TW = address_width_param - cache_width_param + 1;

    typedef enum logic [1:0] {ST_IDLE, ST_ACCESS, ST_COMPARE} seq_type;

    typedef struct packed {
        seq_type             st;
        logic                pwr_req;
        logic                ack_meta;
        logic                ack_sync;
        logic                rd;
        logic                wr;
        logic                way;
        logic [IW-1:0]       idx;
        logic [TW-1:0]       tag;
        logic                hit;
        logic                miss;
        logic                rvalid;
        logic                rhit;
        logic                rway;
        logic [LINE_BITS-1:0] wdata;
        logic [LINE_BITS-1:0] rdata;
    } state_type;

    state_type s_q;
    state_type s_d;
    logic      powered;
    logic      hit0;
    logic      hit1;
    logic      way1_en;

    // Access allowed only with request held and acknowledge seen
    assign powered      = s_q.pwr_req & s_q.ack_sync & power_request_bit;
    assign lookup_ready = (s_q.st == ST_IDLE) & powered & ~fill_valid;
    assign fill_ready   = (s_q.st == ST_IDLE) & powered;
    assign way1_en      = WAY1_PRESENT;
    assign hit0 = (way0_tag_rdata == s_q.tag);
    assign hit1 = way1_en & (way1_tag_rdata == s_q.tag);

    // Next state: power handshake and lookup/fill sequence
    always_comb begin
        s_d          = s_q;
        // Keep the request up while an access is in flight, so the
        // SRAMs cannot lose power under an issued read or write
        s_d.pwr_req  = power_request_bit
                     | ((s_q.st != ST_IDLE) & s_q.pwr_req);
        s_d.ack_meta = sram_power_up_ack;
        s_d.ack_sync = s_q.ack_meta;
        s_d.hit      = 1'b0;
        s_d.miss     = 1'b0;
        s_d.rvalid   = 1'b0;
        unique case (s_q.st)
            ST_IDLE: begin
                s_d.rd = 1'b0;
                s_d.wr = 1'b0;
                if (fill_valid && fill_ready) begin
                    s_d.st    = ST_ACCESS;
                    s_d.wr    = 1'b1;
                    s_d.way   = fill_way & way1_en;
                    s_d.idx   = fill_addr[cache_width_param-1:LINE_OFFSET];
                    s_d.tag   = {TAG_VALID,
                        fill_addr[address_width_param-1:cache_width_param]};
                    s_d.wdata = fill_data;
                end else if (lookup_valid && lookup_ready) begin
                    s_d.st  = ST_ACCESS;
                    s_d.rd  = 1'b1;
                    s_d.idx = lookup_addr[cache_width_param-1:LINE_OFFSET];
                    s_d.tag = {TAG_VALID,
                        lookup_addr[address_width_param-1:cache_width_param]};
                end
            end
            ST_ACCESS: begin
                // SRAM ports are live this cycle; writes end here
                s_d.st = s_q.rd ? ST_COMPARE : ST_IDLE;
                s_d.rd = 1'b0;
                s_d.wr = 1'b0;
            end
            ST_COMPARE: begin
                // Read data arrives one cycle after the address cycle
                s_d.st     = ST_IDLE;
                s_d.hit    = hit0 | hit1;
                s_d.miss   = ~(hit0 | hit1);
                s_d.rvalid = 1'b1;
                s_d.rhit   = hit0 | hit1;
                s_d.rway   = ~hit0 & hit1;
                s_d.rdata  = hit0 ? way0_line_rdata
                           : (hit1 ? way1_line_rdata : '0);
            end
        endcase
    end

    // State register; line buffers keep their value on partial reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q.st       <= ST_IDLE;
            s_q.pwr_req  <= 1'b0;
            s_q.ack_meta <= 1'b0;
            s_q.ack_sync <= 1'b0;
            s_q.rd       <= 1'b0;
            s_q.wr       <= 1'b0;
            s_q.hit      <= 1'b0;
            s_q.miss     <= 1'b0;
            s_q.rvalid   <= 1'b0;
            if (RESET_ALL_REGS) begin
                s_q.way   <= 1'b0;
                s_q.idx   <= '0;
                s_q.tag   <= '0;
                s_q.rhit  <= 1'b0;
                s_q.rway  <= 1'b0;
                s_q.wdata <= '0;
                s_q.rdata <= '0;
            end
        end else begin
            s_q <= s_d;
        end
    end

    // Power and answer outputs, all straight from flops
    assign sram_power_up_request = s_q.pwr_req;
    assign power_state_field     = s_q.ack_sync;
    assign resp_valid            = s_q.rvalid;
    assign resp_hit              = s_q.rhit;
    assign resp_way              = s_q.rway;
    assign resp_data             = s_q.rdata;
    assign lookup_hit_pulse      = s_q.hit;
    assign lookup_miss_pulse     = s_q.miss;

    // Way 0 ports; lookups read both ways, fills write one
    assign way0_line_addr        = s_q.idx;
    assign way0_line_write       = s_q.wr & ~s_q.way;
    assign way0_line_word_read   = s_q.rd ? ALL_WORDS : NO_WORDS;
    assign way0_line_word_select = (s_q.rd | (s_q.wr & ~s_q.way))
                                 ? ALL_WORDS : NO_WORDS;
    assign way0_line_wdata       = s_q.wdata;
    assign way0_tag_addr         = s_q.idx;
    assign way0_tag_write        = s_q.wr & ~s_q.way;
    assign way0_tag_read         = s_q.rd;
    assign way0_tag_select       = s_q.rd | (s_q.wr & ~s_q.way);
    assign way0_tag_wdata        = s_q.tag;

    // Way 1 ports exist only when built; otherwise held quiet
    generate
        if (WAY1_PRESENT) begin : g_way1
            assign way1_line_addr        = s_q.idx;
            assign way1_line_write       = s_q.wr & s_q.way;
            assign way1_line_word_read   = s_q.rd ? ALL_WORDS : NO_WORDS;
            assign way1_line_word_select = (s_q.rd | (s_q.wr & s_q.way))
                                         ? ALL_WORDS : NO_WORDS;
            assign way1_line_wdata       = s_q.wdata;
            assign way1_tag_addr         = s_q.idx;
            assign way1_tag_write        = s_q.wr & s_q.way;
            assign way1_tag_read         = s_q.rd;
            assign way1_tag_select       = s_q.rd | (s_q.wr & s_q.way);
            assign way1_tag_wdata        = s_q.tag;
        end else begin : g_no_way1
            assign way1_line_addr        = '0;
            assign way1_line_write       = 1'b0;
            assign way1_line_word_read   = NO_WORDS;
            assign way1_line_word_select = NO_WORDS;
            assign way1_line_wdata       = '0;
            assign way1_tag_addr         = '0;
            assign way1_tag_write        = 1'b0;
            assign way1_tag_read         = 1'b0;
            assign way1_tag_select       = 1'b0;
            assign way1_tag_wdata        = '0;
        end
    endgenerate

    // Checks on the sequencing above
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_access_needs_power: assert property (
        (way0_tag_select || way0_line_word_select != NO_WORDS)
        |-> (sram_power_up_request && power_state_field))
        else $error("SRAM access without acknowledged power");
    a_ack_two_flops: assert property (
        $rose(power_state_field) |-> $past(sram_power_up_ack, 2))
        else $error("Acknowledge not passed through two flops");
    a_request_held_busy: assert property (
        (s_q.st != ST_IDLE && sram_power_up_request)
        |=> sram_power_up_request)
        else $error("Power request dropped during access");
    a_lookup_latency: assert property (
        (lookup_valid && lookup_ready)
        |-> ##1 way0_tag_read ##2 (lookup_hit_pulse ^ lookup_miss_pulse))
        else $error("Lookup did not answer three cycles later");
    a_hit_single_cycle: assert property (
        lookup_hit_pulse |=> !lookup_hit_pulse && !lookup_miss_pulse)
        else $error("Hit pulse longer than one cycle");
    a_miss_single_cycle: assert property (
        lookup_miss_pulse |=> !lookup_miss_pulse && !lookup_hit_pulse)
        else $error("Miss pulse longer than one cycle");
    a_fill_write_cycle: assert property (
        (fill_valid && fill_ready) |=> ((way0_line_write ^ way1_line_write)
        && (way0_line_wdata == $past(fill_data))))
        else $error("Fill did not write one way next cycle");
    a_word_select_full: assert property (
        way0_tag_read |-> (way0_line_word_read == ALL_WORDS
        && way0_line_word_select == ALL_WORDS))
        else $error("Line read without all word controls");
    a_way1_quiet: assert property (
        !way1_en |-> (!way1_line_write && way1_line_word_select == NO_WORDS))
        else $error("Absent way 1 drove its SRAM");

    c_lookup_hit:  cover property (lookup_hit_pulse);
    c_lookup_miss: cover property (lookup_miss_pulse);
    c_fill_way1:   cover property (way1_line_write);
    c_hit_way1:    cover property (resp_valid && resp_hit && resp_way);
endmodule : flash_cache_sram_ports

// >>> flash_cache_sram_pkg.sv
/*
 * Constants shared by the flash cache SRAM side port logic.
 * Assumes SRAM macros with one cycle read latency, 128-bit lines.
 */
package flash_cache_sram_pkg;
    localparam int LINE_BITS   = 128; // One cache line per data SRAM word
    localparam int WORD_COUNT  = 4;   // 32-bit words per line
    localparam int LINE_OFFSET = 4;   // Byte offset bits inside a line
    localparam int DEF_CW      = 12;  // Default cache width parameter
    localparam int DEF_AW      = 32;  // Default address width parameter
    localparam logic [WORD_COUNT-1:0] ALL_WORDS = 4'hf;
    localparam logic [WORD_COUNT-1:0] NO_WORDS  = 4'h0;
    localparam logic                  TAG_VALID = 1'h1;
endpackage : flash_cache_sram_pkg

// >>> sram_partner_model.sv
/*
 * Behavioural SRAM macros for one cache way and an SRAM power controller.
 * Assumes one clock shared with the design, one cycle read latency.
 */
`timescale 1ns/1ps
module sram_way_model #(
    parameter int AWID = 8,
    parameter int TWID = 21
) (
    input  wire logic            clk,
    input  wire logic [AWID-1:0] line_addr,
    input  wire logic            line_write,
    input  wire logic [3:0]      line_word_read,
    input  wire logic [3:0]      line_word_select,
    input  wire logic [127:0]    line_wdata,
    output logic      [127:0]    line_rdata,
    input  wire logic [AWID-1:0] tag_addr,
    input  wire logic            tag_write,
    input  wire logic            tag_read,
    input  wire logic            tag_select,
    input  wire logic [TWID-1:0] tag_wdata,
    output logic      [TWID-1:0] tag_rdata
);
    // Tags start invalid so an unfilled way reads as a clean miss
    logic [127:0]    line_mem [2**AWID] = '{default: '0};
    logic [TWID-1:0] tag_mem  [2**AWID] = '{default: '0};
    // Idle ports show inverted data so a late sample cannot pass
    always @(posedge clk) begin
        if (line_write && line_word_select == 4'hf)
            line_mem[line_addr] <= line_wdata;
        for (int k = 0; k < 4; k++) begin
            line_rdata[32*k+:32] <=
                (line_word_select[k] && line_word_read[k]) ?
                line_mem[line_addr][32*k+:32] : ~line_rdata[32*k+:32];
        end
        if (tag_select && tag_write)
            tag_mem[tag_addr] <= tag_wdata;
        tag_rdata <= (tag_select && tag_read) ? tag_mem[tag_addr]
                                              : ~tag_rdata;
    end
endmodule : sram_way_model

module sram_power_model (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic req,
    output logic      ack
);
    logic [1:0] cnt_q;
    // Ack only after the SRAMs settle, off the edge as it is async
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 2'h0;
            ack <= 1'b0;
        end else if (!req) begin
            cnt_q <= 2'h0;
            ack <= #3 1'b0;
        end else if (cnt_q != 2'h3) begin
            cnt_q <= cnt_q + 2'h1;
        end else begin
            ack <= #3 1'b1;
        end
    end
endmodule : sram_power_model

// >>> flash_cache_sram_ports_test.sv
/*
 * Self-checking bench for the SRAM side ports of the flash cache.
 * Assumes the partner models above and the package defaults.
 */
`timescale 1ns/1ps
module flash_cache_sram_ports_test;
    import flash_cache_sram_pkg::*;
    localparam int CW = DEF_CW;
    localparam int AW = DEF_AW;
    logic clk = 1'b0, rst_n = 1'b0, power_request_bit = 1'b0;
    logic power_state_field, sram_power_up_request, sram_power_up_ack;
    logic lookup_valid = 1'b0, fill_valid = 1'b0, fill_way = 1'b0;
    logic [AW-1:0] lookup_addr = '0, fill_addr = '0;
    logic [127:0] fill_data = '0, resp_data;
    logic lookup_ready, resp_valid, resp_hit, resp_way, fill_ready;
    logic lookup_miss_pulse, lookup_hit_pulse;
    logic [CW-5:0] way0_line_addr, way1_line_addr, way0_tag_addr;
    logic [CW-5:0] way1_tag_addr;
    logic way0_line_write, way1_line_write, way0_tag_write, way1_tag_write;
    logic way0_tag_read, way1_tag_read, way0_tag_select, way1_tag_select;
    logic [3:0] way0_line_word_read, way0_line_word_select;
    logic [3:0] way1_line_word_read, way1_line_word_select;
    logic [127:0] way0_line_wdata, way0_line_rdata;
    logic [127:0] way1_line_wdata, way1_line_rdata;
    logic [AW-CW:0] way0_tag_wdata, way0_tag_rdata;
    logic [AW-CW:0] way1_tag_wdata, way1_tag_rdata;
    logic solo_w0_write, solo_w1_write, solo_w1_tag_write, solo_w1_tag_read;
    logic [3:0] solo_w1_read, solo_w1_select;
    int fail_count = 0;
    int checks = 0;
    always #5 clk = ~clk; // Also the register port clock
    flash_cache_sram_ports flash_cache_sram_ports_inst (.*);
    sram_way_model #(.AWID(CW-4), .TWID(AW-CW+1)) way0_model_inst (
        .clk, .line_addr(way0_line_addr), .line_write(way0_line_write),
        .line_word_read(way0_line_word_read), .line_wdata(way0_line_wdata),
        .line_word_select(way0_line_word_select),
        .line_rdata(way0_line_rdata), .tag_addr(way0_tag_addr),
        .tag_write(way0_tag_write), .tag_read(way0_tag_read),
        .tag_select(way0_tag_select), .tag_wdata(way0_tag_wdata),
        .tag_rdata(way0_tag_rdata));
    sram_way_model #(.AWID(CW-4), .TWID(AW-CW+1)) way1_model_inst (
        .clk, .line_addr(way1_line_addr), .line_write(way1_line_write),
        .line_word_read(way1_line_word_read), .line_wdata(way1_line_wdata),
        .line_word_select(way1_line_word_select),
        .line_rdata(way1_line_rdata), .tag_addr(way1_tag_addr),
        .tag_write(way1_tag_write), .tag_read(way1_tag_read),
        .tag_select(way1_tag_select), .tag_wdata(way1_tag_wdata),
        .tag_rdata(way1_tag_rdata));
    sram_power_model sram_power_model_inst (.clk, .rst_n,
        .req(sram_power_up_request), .ack(sram_power_up_ack));
    // Same stimulus into a build without way 1
    flash_cache_sram_ports #(.WAY1_PRESENT(1'b0), .RESET_ALL_REGS(1'b0))
        flash_cache_sram_ports_solo_inst (.*,
        .power_state_field(), .sram_power_up_request(), .lookup_ready(),
        .resp_valid(), .resp_hit(), .resp_way(), .resp_data(),
        .fill_ready(), .way0_line_addr(), .way0_line_write(solo_w0_write),
        .way0_line_word_read(), .way0_line_word_select(),
        .way0_line_wdata(), .way1_line_addr(),
        .way1_line_write(solo_w1_write), .way1_line_word_read(solo_w1_read),
        .way1_line_word_select(solo_w1_select), .way1_line_wdata(),
        .way0_tag_addr(), .way0_tag_write(), .way0_tag_read(),
        .way0_tag_select(), .way0_tag_wdata(), .way1_tag_addr(),
        .way1_tag_write(solo_w1_tag_write), .way1_tag_read(solo_w1_tag_read),
        .way1_tag_select(), .way1_tag_wdata(), .lookup_miss_pulse(),
        .lookup_hit_pulse());
    // Compare one value, widened to a line
    task chk(input logic [127:0] got, input logic [127:0] exp,
             input string msg);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask : chk
    // Raise power and wait for the synchronised status
    task t_power;
        chk(sram_power_up_request, 1'b0, "request after reset");
        chk(lookup_ready, 1'b0, "ready while unpowered");
        power_request_bit = 1'b1;
        @(negedge clk);
        chk(sram_power_up_request, 1'b1, "request late");
        chk(power_state_field, 1'b0, "status before ack");
        for (int i = 0; i < 20 && power_state_field !== 1'b1; i++)
            @(negedge clk);
        chk(sram_power_up_ack, 1'b1, "status without ack");
        chk(lookup_ready, 1'b1, "ready after power");
        $display("test power done");
    endtask : t_power
    // Offer one fill and stop at its write cycle
    task do_fill(input logic w, input logic [AW-1:0] a,
                 input logic [127:0] d);
        fill_valid = 1'b1;
        fill_way = w;
        fill_addr = a;
        fill_data = d;
        #1;
        for (int i = 0; i < 20 && fill_ready !== 1'b1; i++) #10;
        @(posedge clk);
        for (int i = 0; i < 3; i++) begin
            @(negedge clk);
            fill_valid = 1'b0;
            if ((way0_line_write | way1_line_write) === 1'b1) break;
        end
    endtask : do_fill
    // Offer one lookup and stop at its answer, checking the read cycle
    task do_lookup(input logic [AW-1:0] a);
        lookup_valid = 1'b1;
        lookup_addr = a;
        #1;
        for (int i = 0; i < 20 && lookup_ready !== 1'b1; i++) #10;
        @(posedge clk);
        for (int i = 0; i < 6; i++) begin
            @(negedge clk);
            lookup_valid = 1'b0;
            if (way0_tag_read === 1'b1) begin
                chk(way0_line_word_read, ALL_WORDS, "word read");
                chk(way0_line_addr, a[CW-1:4], "line index");
                chk(way0_tag_addr, a[CW-1:4], "tag index");
                chk(way1_line_word_read, ALL_WORDS, "way1 read");
                chk(way1_tag_read, 1'b1, "way1 tag read");
                chk(solo_w1_read, NO_WORDS, "absent way read");
                chk(solo_w1_tag_read, 1'b0, "absent tag read");
            end
            if (resp_valid === 1'b1) break;
        end
        chk(resp_valid, 1'b1, "no answer");
    endtask : do_lookup
    // Fill way 0, then hit it and miss it with a foreign tag
    task t_way0;
        do_fill(1'b0, 32'h1234_5670, {4{32'hcafe_0001}});
        chk(way0_line_write, 1'b1, "line write");
        chk(way0_line_word_select, ALL_WORDS, "select");
        chk(way0_line_addr, 8'h67, "fill index");
        chk(way0_line_wdata, {4{32'hcafe_0001}}, "wdata");
        chk(way0_tag_write, 1'b1, "tag write");
        chk(way0_tag_wdata, {TAG_VALID, 20'h12345}, "tag data");
        do_lookup(32'h1234_5670);
        chk(lookup_hit_pulse, 1'b1, "hit pulse");
        chk(lookup_miss_pulse, 1'b0, "miss on hit");
        chk(resp_data, {4{32'hcafe_0001}}, "hit data");
        chk(resp_hit, 1'b1, "hit flag");
        chk(resp_way, 1'b0, "way0 answer");
        @(negedge clk);
        chk(lookup_hit_pulse, 1'b0, "hit pulse long");
        chk(resp_valid, 1'b0, "answer valid long");
        do_lookup(32'h5555_5678);
        chk(lookup_miss_pulse, 1'b1, "miss pulse");
        chk(lookup_hit_pulse, 1'b0, "hit on miss");
        chk(resp_hit, 1'b0, "hit flag on miss");
        @(negedge clk);
        chk(lookup_miss_pulse, 1'b0, "miss pulse long");
        $display("test way0 done");
    endtask : t_way0
    // Fill way 1 and hit there
    task t_way1;
        do_fill(1'b1, 32'h0abc_d120, {4{32'h0bad_f00d}});
        chk(way1_line_write, 1'b1, "way1 write");
        chk(way1_tag_wdata, {TAG_VALID, 20'h0abcd}, "way1 tag");
        chk(way0_line_write, 1'b0, "both ways written");
        chk(way1_line_word_select, ALL_WORDS, "way1 select");
        chk(way1_line_addr, 8'h12, "way1 index");
        chk(way1_line_wdata, {4{32'h0bad_f00d}}, "way1 wdata");
        chk(way1_tag_write, 1'b1, "way1 tag write");
        chk(solo_w0_write, 1'b1, "one-way fill not in way 0");
        chk(solo_w1_write, 1'b0, "absent way written");
        chk(solo_w1_select, NO_WORDS, "absent way selected");
        chk(solo_w1_tag_write, 1'b0, "absent tag written");
        do_lookup(32'h0abc_d120);
        chk(resp_way, 1'b1, "way1 answer");
        chk(resp_hit, 1'b1, "way1 hit flag");
        chk(resp_data, {4{32'h0bad_f00d}}, "way1 data");
        $display("test way1 done");
    endtask : t_way1
    // Reset between edges must clear outputs at once
    task t_reset;
        #2 rst_n = 1'b0;
        #1;
        chk(sram_power_up_request, 1'b0, "async request");
        chk(lookup_ready, 1'b0, "async ready");
        chk(resp_data, '0, "data not cleared by reset");
        @(negedge clk);
        rst_n = 1'b1;
        // Power comes back by itself, then dropping the request stops it
        @(negedge clk);
        chk(sram_power_up_request, 1'b1, "request after release");
        chk(power_state_field, 1'b0, "status kept through reset");
        for (int i = 0; i < 20 && power_state_field !== 1'b1; i++)
            @(negedge clk);
        chk(lookup_ready, 1'b1, "ready after repower");
        power_request_bit = 1'b0;
        #1;
        chk(lookup_ready, 1'b0, "ready after request drop");
        @(negedge clk);
        chk(sram_power_up_request, 1'b0, "request not dropped");
        $display("test reset done");
    endtask : t_reset
    task finish_test;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : finish_test
    initial begin
        repeat (8) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        t_power;
        t_way0;
        t_way1;
        t_reset;
        finish_test;
    end
    // A full run takes far less than this span
    initial begin
        #20000;
        fail_count++;
        finish_test;
    end
endmodule : flash_cache_sram_ports_test
